// [speed_loop_pkg.sv]
// How it works
// - PI by default, P when condition holds
// - Mode code picks compared quantity and threshold
// - Code 4 keeps PI permanently
// - Codes 0-3: P while quantity exceeds threshold
// - Defaults: torque code, threshold 200
// - Speed source 0 internal, 1 model following
// - Speed source 2 offset object, 3 cubic
// - Torque source 0 selects internal value
// - Torque sources 1-3 mirror speed sources
// - Model following sources need select 1 or 2
// - Speed FF is position derivative times gain
// - Torque FF: speed derivative, inertia, gain
// - Both internal terms low-pass filtered, own times, except the torque term in variant 2
// - Variant 0 general, 2 high-speed torque FF
// - Offsets are signed 32 and 16 bit
// - Sources 2 and 3 need fieldbus control
// - Cubic depends on submode object value -1
package speed_loop_pkg;

  // **********************************************************************
  // Object dictionary indices
  // **********************************************************************
  localparam logic [15:0] IDX_SPEED_FF_OFFSET  = 16'h60b1;
  localparam logic [15:0] IDX_TORQUE_FF_OFFSET = 16'h60b2;
  localparam logic [15:0] IDX_INTERP_SUBMODE   = 16'h60c0;

  // **********************************************************************
  // Reset values and fixed codes
  // **********************************************************************
  localparam logic [31:0] SPEED_OFFSET_RESET   = 32'h0000_0000;
  localparam logic [15:0] TORQUE_OFFSET_RESET  = 16'h0000;
  localparam logic [15:0] SUBMODE_RESET        = 16'h0000;
  localparam logic [15:0] SUBMODE_CUBIC        = 16'hffff;  // Signed -1.
  localparam logic [15:0] TORQUE_THRESH_DEF    = 16'h00c8;  // 200 percent.
  localparam logic [3:0]  FILTER_SHIFT_MAX     = 4'hf;
  // Percent scaling of the feedforward products.
  localparam logic signed [63:0] SPEED_FF_DIV  = 64'sh0000_0000_0000_0064;
  localparam logic signed [63:0] TORQUE_FF_DIV = 64'sh0000_0000_0000_2710;

  // **********************************************************************
  // Mode encodings
  // **********************************************************************
  typedef enum logic [2:0] {
    PPI_TORQUE    = 3'h0,
    PPI_DEVIATION = 3'h1,
    PPI_ACCEL     = 3'h2,
    PPI_SPEED     = 3'h3,
    PPI_FIXED_PI  = 3'h4
  } ppi_mode_t;

  typedef enum logic [1:0] {
    FF_INTERNAL = 2'h0,
    FF_MODEL    = 2'h1,
    FF_OFFSET   = 2'h2,
    FF_CUBIC    = 2'h3
  } ff_source_t;

  localparam logic [1:0] VARIANT_GENERAL   = 2'h0;
  localparam logic [1:0] VARIANT_HIGHSPEED = 2'h2;
  localparam logic [1:0] MFC_OFF           = 2'h0;

  // **********************************************************************
  // Carriers
  // **********************************************************************
  // Quantities compared by the P/PI decision.
  typedef struct packed {
    logic signed [15:0] torque_ref_pct;
    logic signed [31:0] deviation;
    logic signed [31:0] accel_ref;
    logic signed [31:0] speed_ref;
  } ppi_sample_t;

  // Thresholds, one per quantity, taken immediately.
  typedef struct packed {
    logic [15:0] torque_ref_switch_threshold;
    logic [31:0] deviation_switch_threshold;
    logic [31:0] accel_ref_switch_threshold;
    logic [31:0] speed_ref_switch_threshold;
  } ppi_thresh_t;

  // Mode codes, held until restart.
  typedef struct packed {
    ppi_mode_t  speed_loop_mode_select;
    ff_source_t speed_ff_source_select;
    ff_source_t torque_ff_source_select;
    logic [1:0] torque_ff_variant_select;
    logic [1:0] model_follow_select;
  } mode_cfg_t;

  // Tunings, taken immediately.
  typedef struct packed {
    logic [15:0] speed_ff_gain;
    logic [3:0]  speed_ff_filter_time;
    logic [15:0] torque_ff_gain;
    logic [3:0]  torque_ff_filter_time;
    logic [15:0] load_inertia_pct;
  } ff_tune_t;

  localparam mode_cfg_t MODE_CFG_RESET = '{
    speed_loop_mode_select:   PPI_TORQUE,
    speed_ff_source_select:   FF_INTERNAL,
    torque_ff_source_select:  FF_INTERNAL,
    torque_ff_variant_select: VARIANT_GENERAL,
    model_follow_select:      MFC_OFF
  };

endpackage : speed_loop_pkg

// [ff_derivative.sv]
`timescale 1ns/1ps
// Differentiates a sample once per control period and scales it.
module ff_derivative
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Control period strobe.
  input  wire logic               tick,
  // Sample and gains.
  input  wire logic signed [31:0] sample,
  input  wire logic        [15:0] gain_a,
  input  wire logic        [15:0] gain_b,
  input  wire logic signed [63:0] divisor,
  // Scaled derivative.
  output logic signed      [31:0] scaled
);

  logic signed [31:0] prev;      // Sample of the previous period.
  logic signed [32:0] diff;      // One-period difference.
  logic signed [63:0] product;   // Difference times both gains.

  // Differences span one period.
  assign diff    = 33'(sample) - 33'(prev);
  assign product = 64'(diff) * $signed({1'b0, gain_a}) * $signed({1'b0, gain_b});
  assign scaled  = 32'(product / divisor);

  // The previous sample only moves on a period strobe.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      prev <= '0;
    else if (tick)
      prev <= sample;
  end

endmodule : ff_derivative

// [ff_lowpass.sv]
`timescale 1ns/1ps
// First-order low-pass: y += (x - y) >> shift, once per control period.
module ff_lowpass
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Control period strobe.
  input  wire logic               tick,
  // Filter time as a power-of-two shift; zero passes the input through.
  input  wire logic        [3:0]  shift,
  input  wire logic signed [31:0] din,
  // Filtered value.
  output logic signed      [31:0] dout
);

  logic signed [32:0] err;       // Distance to the input.
  logic signed [32:0] step;      // Shifted correction.

  // A shift keeps the filter division-free; time constants come in octaves.
  assign err  = 33'(din) - 33'(dout);
  assign step = err >>> shift;

  // The state moves once per period; a new shift acts on the next one.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      dout <= '0;
    else if (tick)
      dout <= 32'(33'(dout) + step);
  end

endmodule : ff_lowpass

// [speed_loop_ppi_and_feedforward.sv]
`timescale 1ns/1ps
// Speed-loop P/PI selection and feedforward source selection.
module speed_loop_ppi_and_feedforward
(
  // Clock and reset.
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // Control period strobe and restart request.
  input  wire logic                        ctl_tick,
  input  wire logic                        restart,
  // Parameter settings.
  input  wire speed_loop_pkg::mode_cfg_t   mode_cfg,
  input  wire speed_loop_pkg::ppi_thresh_t ppi_thresh,
  input  wire speed_loop_pkg::ff_tune_t    ff_tune,
  // Loop quantities.
  input  wire speed_loop_pkg::ppi_sample_t ppi_sample,
  input  wire logic signed [31:0]          pos_ref,
  input  wire logic signed [31:0]          speed_ref_ff,
  // External feedforward producers.
  input  wire logic signed [31:0]          model_speed_ff,
  input  wire logic signed [31:0]          model_torque_ff,
  input  wire logic signed [31:0]          cubic_speed_ff,
  input  wire logic signed [31:0]          cubic_torque_ff,
  input  wire logic                        bus_control,
  // Object dictionary access.
  input  wire logic                        obj_wr_en,
  input  wire logic                        obj_rd_en,
  input  wire logic        [15:0]          obj_index,
  input  wire logic        [31:0]          obj_wdata,
  output logic             [31:0]          obj_rdata,
  output logic                             obj_ack,
  output logic                             obj_error,
  // Loop outputs.
  output logic                             p_only,
  output logic signed      [31:0]          speed_ff,
  output logic signed      [31:0]          torque_ff,
  output logic                             speed_ff_valid,
  output logic                             torque_ff_valid,
  output speed_loop_pkg::mode_cfg_t        active_cfg
);

  // **********************************************************************
  // Object dictionary entries
  // **********************************************************************

  logic signed [31:0] speed_feedforward_offset;      // Host speed offset.
  logic signed [15:0] torque_feedforward_offset;     // Host torque offset.
  logic signed [15:0] interpolation_submode_select;  // Interpolation mode.

  wire hit_speed  = (obj_index == speed_loop_pkg::IDX_SPEED_FF_OFFSET);
  wire hit_torque = (obj_index == speed_loop_pkg::IDX_TORQUE_FF_OFFSET);
  wire hit_sub    = (obj_index == speed_loop_pkg::IDX_INTERP_SUBMODE);
  wire obj_known  = hit_speed | hit_torque | hit_sub;
  wire obj_req    = obj_wr_en | obj_rd_en;

  // Read data, 16-bit entries sign-extended to the full word.
  wire [31:0] obj_read_mux =
    hit_speed  ? speed_feedforward_offset :
    hit_torque ? {{16{torque_feedforward_offset[15]}}, torque_feedforward_offset} :
    hit_sub    ? {{16{interpolation_submode_select[15]}}, interpolation_submode_select} :
                 32'h0000_0000;

  // Writes store the signed entry; a 16-bit entry keeps the low half.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      speed_feedforward_offset     <= speed_loop_pkg::SPEED_OFFSET_RESET;
      torque_feedforward_offset    <= speed_loop_pkg::TORQUE_OFFSET_RESET;
      interpolation_submode_select <= speed_loop_pkg::SUBMODE_RESET;
    end
    else if (obj_wr_en)
    begin
      if (hit_speed)
        speed_feedforward_offset <= obj_wdata;
      if (hit_torque)
        torque_feedforward_offset <= obj_wdata[15:0];
      if (hit_sub)
        interpolation_submode_select <= obj_wdata[15:0];
    end
  end

  // One acknowledge per request; unknown indices answer with an error.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      obj_rdata <= '0;
      obj_ack   <= 1'b0;
      obj_error <= 1'b0;
    end
    else
    begin
      obj_ack   <= obj_req;
      obj_error <= obj_req & ~obj_known;
      if (obj_rd_en)
        obj_rdata <= obj_read_mux;
    end
  end

  // **********************************************************************
  // Mode codes held until restart
  // **********************************************************************

  logic cfg_load;  // Pending capture of the mode codes.

  // Codes are caught after reset release and on each restart;
  // a change in between does not reach the loop.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cfg_load   <= 1'b1;
      active_cfg <= speed_loop_pkg::MODE_CFG_RESET;
    end
    else
    begin
      cfg_load <= 1'b0;
      if (cfg_load | restart)
        active_cfg <= mode_cfg;
    end
  end

  // **********************************************************************
  // P/PI decision
  // **********************************************************************

  // Magnitude of a signed word.
  function automatic logic [31:0] magnitude(input logic signed [31:0] v);
    magnitude = v[31] ? 32'(-v) : v;
  endfunction : magnitude

  wire [31:0] mag_torque = magnitude(32'(ppi_sample.torque_ref_pct));
  wire [31:0] mag_dev    = magnitude(ppi_sample.deviation);
  wire [31:0] mag_accel  = magnitude(ppi_sample.accel_ref);
  wire [31:0] mag_speed  = magnitude(ppi_sample.speed_ref);

  wire over_torque = mag_torque > 32'(ppi_thresh.torque_ref_switch_threshold);
  wire over_dev    = mag_dev    > ppi_thresh.deviation_switch_threshold;
  wire over_accel  = mag_accel  > ppi_thresh.accel_ref_switch_threshold;
  wire over_speed  = mag_speed  > ppi_thresh.speed_ref_switch_threshold;

  logic next_p_only;  // Decision for this period.

  // Only strictly above the threshold selects P; equal stays PI.
  always_comb
  begin
    case (active_cfg.speed_loop_mode_select)
      speed_loop_pkg::PPI_TORQUE:    next_p_only = over_torque;
      speed_loop_pkg::PPI_DEVIATION: next_p_only = over_dev;
      speed_loop_pkg::PPI_ACCEL:     next_p_only = over_accel;
      speed_loop_pkg::PPI_SPEED:     next_p_only = over_speed;
      speed_loop_pkg::PPI_FIXED_PI:  next_p_only = 1'b0;
      default:                       next_p_only = 1'b0;
    endcase
  end

  // Refreshed once per control period, held between.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      p_only <= 1'b0;
    else if (ctl_tick)
      p_only <= next_p_only;
  end

  // **********************************************************************
  // Internal feedforward
  // **********************************************************************

  logic signed [31:0] raw_ff   [2];  // Scaled derivatives.
  logic signed [31:0] filt_ff  [2];  // Filtered derivatives.
  logic signed [31:0] deriv_in [2];  // Differentiated references.
  logic        [15:0] gain_a   [2];  // First gain of each path.
  logic        [15:0] gain_b   [2];  // Second gain of each path.
  logic        [3:0]  shift    [2];  // Filter time of each path.
  logic signed [63:0] divisor  [2];  // Percent scaling of each path.

  // The high-speed variant skips smoothing: a zero shift trades noise for phase.
  // The term still comes from the filter state, so it holds for the whole period.
  wire high_speed = (active_cfg.torque_ff_variant_select == speed_loop_pkg::VARIANT_HIGHSPEED);

  // Path 0 is speed, path 1 is torque.
  assign deriv_in[0] = pos_ref;
  assign gain_a[0]   = ff_tune.speed_ff_gain;
  assign gain_b[0]   = 16'h0001;
  assign divisor[0]  = speed_loop_pkg::SPEED_FF_DIV;
  assign shift[0]    = ff_tune.speed_ff_filter_time;
  assign deriv_in[1] = speed_ref_ff;
  assign gain_a[1]   = ff_tune.load_inertia_pct;
  assign gain_b[1]   = ff_tune.torque_ff_gain;
  assign divisor[1]  = speed_loop_pkg::TORQUE_FF_DIV;
  assign shift[1]    = high_speed ? '0 : ff_tune.torque_ff_filter_time;

  genvar path;
  generate
    for (path = 0; path < 2; path++)
    begin : g_path
      // Derivative times gains, refreshed per period.
      ff_derivative u_deriv
      (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (ctl_tick),
        .sample  (deriv_in[path]),
        .gain_a  (gain_a[path]),
        .gain_b  (gain_b[path]),
        .divisor (divisor[path]),
        .scaled  (raw_ff[path])
      );
      // Smoothing of the differentiation noise.
      ff_lowpass u_lowpass
      (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (ctl_tick),
        .shift   (shift[path]),
        .din     (raw_ff[path]),
        .dout    (filt_ff[path])
      );
    end
  endgenerate

  wire signed [31:0] internal_torque = filt_ff[1];

  // **********************************************************************
  // Source selection
  // **********************************************************************

  // Preconditions of the non-internal sources.
  wire mfc_on   = (active_cfg.model_follow_select != speed_loop_pkg::MFC_OFF) &
                  (active_cfg.model_follow_select != 2'h3);
  wire cubic_on = bus_control &
                  (interpolation_submode_select == speed_loop_pkg::SUBMODE_CUBIC);

  // Availability of a source code, shared by both paths.
  function automatic logic source_ok(input speed_loop_pkg::ff_source_t src,
                                     input logic mfc, input logic bus,
                                     input logic cubic);
    case (src)
      speed_loop_pkg::FF_INTERNAL: source_ok = 1'b1;
      speed_loop_pkg::FF_MODEL:    source_ok = mfc;
      speed_loop_pkg::FF_OFFSET:   source_ok = bus;
      speed_loop_pkg::FF_CUBIC:    source_ok = cubic;
      default:                     source_ok = 1'b0;
    endcase
  endfunction : source_ok

  wire speed_ok  = source_ok(active_cfg.speed_ff_source_select, mfc_on, bus_control, cubic_on);
  wire torque_ok = source_ok(active_cfg.torque_ff_source_select, mfc_on, bus_control, cubic_on);

  logic signed [31:0] next_speed_ff;   // Selected speed feedforward.
  logic signed [31:0] next_torque_ff;  // Selected torque feedforward.

  // Speed source mux; an unavailable source contributes nothing.
  always_comb
  begin
    case (active_cfg.speed_ff_source_select)
      speed_loop_pkg::FF_INTERNAL: next_speed_ff = filt_ff[0];
      speed_loop_pkg::FF_MODEL:    next_speed_ff = model_speed_ff;
      speed_loop_pkg::FF_OFFSET:   next_speed_ff = speed_feedforward_offset;
      speed_loop_pkg::FF_CUBIC:    next_speed_ff = cubic_speed_ff;
      default:                     next_speed_ff = '0;
    endcase
    if (!speed_ok)
      next_speed_ff = '0;
  end

  // Torque source mux, same availability as the speed codes.
  always_comb
  begin
    case (active_cfg.torque_ff_source_select)
      speed_loop_pkg::FF_INTERNAL: next_torque_ff = internal_torque;
      speed_loop_pkg::FF_MODEL:    next_torque_ff = model_torque_ff;
      speed_loop_pkg::FF_OFFSET:   next_torque_ff = 32'(torque_feedforward_offset);
      speed_loop_pkg::FF_CUBIC:    next_torque_ff = cubic_torque_ff;
      default:                     next_torque_ff = '0;
    endcase
    if (!torque_ok)
      next_torque_ff = '0;
  end

  // **********************************************************************
  // Output registers
  // **********************************************************************

  logic tick_d;  // Period strobe one edge late, after the filters moved.

  // Outputs follow one edge after the filters move.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tick_d          <= 1'b0;
      speed_ff        <= '0;
      torque_ff       <= '0;
      speed_ff_valid  <= 1'b0;
      torque_ff_valid <= 1'b0;
    end
    else
    begin
      tick_d <= ctl_tick;
      if (tick_d)
      begin
        speed_ff        <= next_speed_ff;
        torque_ff       <= next_torque_ff;
        speed_ff_valid  <= speed_ok;
        torque_ff_valid <= torque_ok;
      end
    end
  end

endmodule : speed_loop_ppi_and_feedforward

// [speed_loop_ppi_and_feedforward_assertions.sv]
`timescale 1ns/1ps
// ********
// Checker
// ********
module speed_loop_checker
(
  // Clock and reset.
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  // Inputs watched.
  input wire logic                        ctl_tick,
  input wire logic                        restart,
  input wire logic                        bus_control,
  input wire logic                        obj_wr_en,
  input wire logic                        obj_rd_en,
  input wire logic [15:0]                 obj_index,
  input wire speed_loop_pkg::mode_cfg_t   mode_cfg,
  input wire speed_loop_pkg::ppi_thresh_t ppi_thresh,
  input wire speed_loop_pkg::ppi_sample_t ppi_sample,
  // Outputs judged.
  input wire logic                        obj_ack,
  input wire logic                        obj_error,
  input wire logic                        p_only,
  input wire logic signed [31:0]          speed_ff,
  input wire logic                        speed_ff_valid,
  input wire logic                        torque_ff_valid,
  input wire speed_loop_pkg::mode_cfg_t   active_cfg
);
  // Requests and mapped indices.
  wire logic        req   = obj_wr_en | obj_rd_en;
  wire logic        known = (obj_index == speed_loop_pkg::IDX_SPEED_FF_OFFSET) |
    (obj_index == speed_loop_pkg::IDX_TORQUE_FF_OFFSET) | (obj_index == speed_loop_pkg::IDX_INTERP_SUBMODE);
  // Torque compared by size.
  wire logic [15:0] t_mag = ppi_sample.torque_ref_pct[15] ? 16'(-ppi_sample.torque_ref_pct) :
    ppi_sample.torque_ref_pct;
  wire logic        t_sel = active_cfg.speed_loop_mode_select == speed_loop_pkg::PPI_TORQUE;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_ack_follows: assert property (req |=> obj_ack)
    else $error("no acknowledge");
  a_error_unknown: assert property (req && !known |=> obj_error)
    else $error("no error flag");
  a_fixed_pi: assert property (ctl_tick && active_cfg.speed_loop_mode_select == speed_loop_pkg::PPI_FIXED_PI
    |=> !p_only) else $error("fixed PI left PI");
  a_torque_over: assert property (ctl_tick && t_sel && t_mag > ppi_thresh.torque_ref_switch_threshold
    |=> p_only) else $error("torque over kept PI");
  a_torque_under: assert property (ctl_tick && t_sel && t_mag <= ppi_thresh.torque_ref_switch_threshold
    |=> !p_only) else $error("torque under left PI");
  a_choice_stands: assert property (!ctl_tick |=> $stable(p_only))
    else $error("choice moved");
  a_cfg_holds: assert property (!restart && $past(rst_n) |=> $stable(active_cfg))
    else $error("codes moved");
  a_restart_takes: assert property (restart |=> active_cfg == $past(mode_cfg))
    else $error("codes not caught");
  a_model_needs: assert property (ctl_tick && active_cfg.torque_ff_source_select == speed_loop_pkg::FF_MODEL
    && active_cfg.model_follow_select == speed_loop_pkg::MFC_OFF |-> ##2 !torque_ff_valid)
    else $error("model source used");
  a_bus_needs: assert property (ctl_tick && active_cfg.speed_ff_source_select == speed_loop_pkg::FF_OFFSET
    ##1 !bus_control |=> !speed_ff_valid) else $error("offset used off bus");
  a_invalid_zero: assert property (!speed_ff_valid |-> speed_ff == 32'sh0)
    else $error("invalid speed not zero");
endmodule : speed_loop_checker

bind speed_loop_ppi_and_feedforward speed_loop_checker u_chk (.*);

// [host_partner.sv]
`timescale 1ns/1ps
// ********
// Host controller model
// ********
module host_partner
(
  // Clock.
  input wire logic        clk_sys,
  // Object port towards the drive.
  output logic            obj_wr_en,
  output logic            obj_rd_en,
  output logic [15:0]     obj_index,
  output logic [31:0]     obj_wdata,
  input wire logic [31:0] obj_rdata,
  input wire logic        obj_ack,
  input wire logic        obj_error
);
  // Idle from time zero.
  initial
  begin
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h0000_0000;
  end
  // One access; released lines show the inverse.
  task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ack, output logic err);
    @(posedge clk_sys);
    #1;
    obj_wr_en = wr;
    obj_rd_en = ~wr;
    obj_index = idx;
    obj_wdata = wd;
    @(posedge clk_sys);
    #1;
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    obj_index = ~idx;
    obj_wdata = ~wd;
    rd = obj_rdata;
    ack = obj_ack;
    err = obj_error;
  endtask : access
endmodule : host_partner

// [speed_loop_ppi_and_feedforward_tb.sv]
`timescale 1ns/1ps
module speed_loop_ppi_and_feedforward_tb;
  // ********
  // Bench signals
  // ********
  logic clk_sys, rst_n, ctl_tick, restart, bus_control, obj_wr_en, obj_rd_en, obj_ack, obj_error;
  logic p_only, speed_ff_valid, torque_ff_valid, ack, err;
  logic signed [31:0] pos_ref, speed_ref_ff, model_speed_ff, model_torque_ff, cubic_speed_ff, cubic_torque_ff;
  logic signed [31:0] speed_ff, torque_ff;
  logic [15:0] obj_index;
  logic [31:0] obj_wdata, obj_rdata, rd;
  speed_loop_pkg::mode_cfg_t   mode_cfg, active_cfg, m;
  speed_loop_pkg::ppi_thresh_t ppi_thresh;
  speed_loop_pkg::ff_tune_t    ff_tune;
  speed_loop_pkg::ppi_sample_t ppi_sample;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  speed_loop_ppi_and_feedforward DUT (.*);
  host_partner host (.*);
  // Clock and hang guard.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // One period; outputs are settled on return.
  task automatic tick();
    @(posedge clk_sys);
    #1 ctl_tick = 1'b1;
    @(posedge clk_sys);
    #1 ctl_tick = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic cfg(input speed_loop_pkg::mode_cfg_t c);
    @(posedge clk_sys);
    #1 mode_cfg = c;
    restart = 1'b1;
    @(posedge clk_sys);
    #1 restart = 1'b0;
    check(active_cfg, c, "codes not caught");
  endtask : cfg
  task automatic obj(input logic wr, input logic [15:0] idx, input logic [31:0] wd, input logic [31:0] exp,
                     input logic xerr);
    host.access(wr, idx, wd, rd, ack, err);
    check(ack, 1'b1, "no acknowledge");
    check(err, xerr, "error flag wrong");
    if (!wr) check(rd, exp, "read wrong");
  endtask : obj
  // Reset state and object entries.
  task automatic t_objects();
    check(p_only, 1'b0, "not PI");
    check(active_cfg, speed_loop_pkg::MODE_CFG_RESET, "codes not default");
    obj(1'b1, speed_loop_pkg::IDX_SPEED_FF_OFFSET, 32'h8000_0001, 32'h0, 1'b0);
    obj(1'b0, speed_loop_pkg::IDX_SPEED_FF_OFFSET, 32'h0, 32'h8000_0001, 1'b0);
    obj(1'b1, speed_loop_pkg::IDX_TORQUE_FF_OFFSET, 32'h0000_fff0, 32'h0, 1'b0);
    obj(1'b0, speed_loop_pkg::IDX_TORQUE_FF_OFFSET, 32'h0, 32'hffff_fff0, 1'b0);
    obj(1'b1, speed_loop_pkg::IDX_INTERP_SUBMODE, 32'h0000_ffff, 32'h0, 1'b0);
    obj(1'b0, speed_loop_pkg::IDX_INTERP_SUBMODE, 32'h0, 32'hffff_ffff, 1'b0);
    obj(1'b1, 16'h6000, 32'h1234_5678, 32'h0, 1'b1);
    obj(1'b0, 16'h6000, 32'h0, 32'h0, 1'b1);
  endtask : t_objects
  // Each code over, negated over, and at threshold.
  task automatic t_ppi();
    logic [31:0] thr [5] = '{32'hc8, 32'h64, 32'h32, 32'h1e, 32'h7fff};
    logic [31:0] v;
    ppi_thresh = '{16'h00c8, 32'h64, 32'h32, 32'h1e};
    for (int c = 0; c < 5; c++)
    begin
      m = speed_loop_pkg::MODE_CFG_RESET;
      m.speed_loop_mode_select = speed_loop_pkg::ppi_mode_t'(c);
      cfg(m);
      for (int k = 0; k < 3; k++)
      begin
        v = (k == 0) ? thr[c] + 1 : (k == 1) ? -(thr[c] + 1) : thr[c];
        ppi_sample = '{v[15:0], v, v, v};
        tick();
        check(p_only, (c < 4 && k < 2), "choice wrong");
      end
    end
  endtask : t_ppi
  // Internal terms, filter step and bypass.
  task automatic t_ff_internal();
    ff_tune = '{16'h00c8, 4'h0, 16'h0032, 4'h0, 16'h00c8};
    m = speed_loop_pkg::MODE_CFG_RESET;
    m.torque_ff_variant_select = speed_loop_pkg::VARIANT_HIGHSPEED;
    cfg(m);
    tick();
    pos_ref = pos_ref + 500;
    speed_ref_ff = speed_ref_ff + 300;
    tick();
    check(speed_ff, 32'd1000, "speed term");
    check(torque_ff, 32'd300, "torque term");
    check({speed_ff_valid, torque_ff_valid}, 2'b11, "not valid");
    ff_tune.speed_ff_filter_time = 4'h1;
    ff_tune.torque_ff_filter_time = 4'h1;
    pos_ref = pos_ref + 400;
    speed_ref_ff = speed_ref_ff + 300;
    tick();
    check(speed_ff, 32'd900, "filter step");
    check(torque_ff, 32'd300, "bypass");
  endtask : t_ff_internal
  // External sources with and without precondition.
  task automatic t_ff_sources();
    logic [31:0] ts [4] = '{32'h0, 32'h1111, 32'h8000_0001, 32'h3333};
    logic [31:0] tt [4] = '{32'h0, 32'h2222, 32'hffff_fff0, 32'h4444};
    for (int s = 1; s < 4; s++)
      for (int ok = 0; ok < 2; ok++)
      begin
        m = speed_loop_pkg::MODE_CFG_RESET;
        m.speed_ff_source_select = speed_loop_pkg::ff_source_t'(s);
        m.torque_ff_source_select = speed_loop_pkg::ff_source_t'(s);
        m.model_follow_select = (s == 1 && ok == 1) ? 2'h1 : 2'h0;
        bus_control = (s == 1) ? 1'b1 : ok[0];
        cfg(m);
        tick();
        check(speed_ff, ok ? ts[s] : 32'h0, "speed source");
        check(torque_ff, ok ? tt[s] : 32'h0, "torque source");
        check({speed_ff_valid, torque_ff_valid}, ok ? 2'b11 : 2'b00, "source valid");
      end
  endtask : t_ff_sources
  initial
  begin
    {rst_n, ctl_tick, restart, bus_control} = 4'h0;
    {pos_ref, speed_ref_ff} = 64'h0;
    {model_speed_ff, model_torque_ff, cubic_speed_ff, cubic_torque_ff} = {32'h1111, 32'h2222, 32'h3333, 32'h4444};
    mode_cfg = speed_loop_pkg::MODE_CFG_RESET;
    {ppi_thresh, ff_tune, ppi_sample} = '0;
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_objects();
    t_ppi();
    t_ff_internal();
    t_ff_sources();
    finish_test();
  end
endmodule : speed_loop_ppi_and_feedforward_tb
